/* File: exec_pkg.sv */
// Purpose: Shared constants and types for the clear, complement and compare execution block.
// Assumes: 32-bit classic Wishbone slave with byte addresses, 125 MHz clk_sys.
// Notes: Offsets are byte addresses; every register occupies one aligned word.
package exec_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_NEXT = 8'h08;
  localparam logic [7:0] OFS_WREG = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_BANK = 8'h14;
  localparam logic [7:0] OFS_WDOG = 8'h18;
  localparam logic [7:0] OFS_PC = 8'h1c;
  localparam logic [7:0] OFS_STACK = 8'h20;
  localparam logic [7:0] OFS_SHADOW = 8'h24;
  localparam logic [7:0] OFS_INDEX = 8'h28;
  localparam logic [7:0] OFS_MADDR = 8'h2c;
  localparam logic [7:0] OFS_MDATA = 8'h30;
  localparam logic [7:0] OFS_EXEC = 8'h34;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;
  localparam int CTRL_EXT = 0;
  localparam int WDOG_EXPIRED_N = 0;
  localparam int WDOG_POWERDOWN_N = 1;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] WREG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] OPC_WATCHDOG_CLEAR = 16'h0004;
  localparam logic [6:0] OPC_CLEAR_HI = 7'h35;
  localparam logic [6:0] OPC_COMPARE_HI = 7'h31;
  localparam logic [5:0] OPC_INVERT_HI = 6'h07;
  localparam logic [6:0] OPC_CALL_HI = 7'h76;
  localparam logic [3:0] OPC_SECOND_WORD = 4'hf;
  localparam logic [3:0] OPC_MOVE_HI = 4'hc;
  localparam logic [7:0] OPC_LOAD_INDEX = 8'hee;
  localparam logic [7:0] OPC_GOTO = 8'hef;

  // ----------------------------------------------------------------
  // Addressing and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [3:0] SFR_BANK = 4'hf;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] RETURN_OFFSET = 21'h000004;
  localparam logic [1:0] Q_DECODE = 2'h0;
  localparam logic [1:0] Q_READ = 2'h1;
  localparam logic [1:0] Q_PROCESS = 2'h2;
  localparam logic [1:0] Q_WRITE = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_NOP} exec_state_t;

endpackage

/* File: operand_address.sv */
// Purpose: Forms the data memory address of a byte-oriented operand.
// Assumes: 4 KiB data space split in 16 banks of 256 bytes.
// Notes: Purely combinational.
`timescale 1ns/1ps
module operand_address (
  input wire logic [7:0] file_addr,
  input wire logic access_sel,
  input wire logic ext_enable,
  input wire logic [3:0] bank,
  input wire logic [11:0] index_base,
  output logic [11:0] data_addr,
  output logic indexed
);

  // ----------------------------------------------------------------
  // Bank selection
  // ----------------------------------------------------------------
  // Low access half maps to bank 0, high half to the special function bank.
  wire low_half = (file_addr <= exec_pkg::ACCESS_LIMIT);
  wire [11:0] access_addr = low_half ? {4'h0, file_addr} : {exec_pkg::SFR_BANK, file_addr};
  wire [11:0] indexed_addr = index_base + {4'h0, file_addr};

  assign indexed = ~access_sel & ext_enable & low_half;
  assign data_addr = access_sel ? {bank, file_addr} : (indexed ? indexed_addr : access_addr);

endmodule

/* File: watchdog_timer.sv */
// Purpose: Free running watchdog counter with postscaler.
// Assumes: Counts every rising clk_sys edge; the real prescale is outside this block.
// Notes: A clear in the same cycle as the final count suppresses the expiry.
`timescale 1ns/1ps
module watchdog_timer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clear,
  output logic [7:0] count_o,
  output logic [3:0] post_o,
  output logic expire_o
);

  logic [7:0] count_ff;
  logic [3:0] post_ff;
  logic expire_ff;

  wire wrap = (count_ff == 8'hff);

  // ----------------------------------------------------------------
  // Counter and postscaler
  // ----------------------------------------------------------------
  // Clear has priority so a cleared watchdog never expires late.
  always_ff @(posedge clk_sys) begin
    if (reset || clear) begin
      count_ff <= 8'h00;
      post_ff <= 4'h0;
      expire_ff <= 1'b0;
    end else begin
      count_ff <= count_ff + 8'h01;
      post_ff <= wrap ? post_ff + 4'h1 : post_ff;
      expire_ff <= wrap & (post_ff == 4'hf);
    end
  end

  assign count_o = count_ff;
  assign post_o = post_ff;
  assign expire_o = expire_ff;

endmodule

/* File: clear_complement_compare_exec.sv */
// Purpose: Executes clear, watchdog clear, invert, compare-equal-skip and call instructions.
// Assumes: Software loads the next word, then the instruction word, over Wishbone.
// Notes: Each instruction cycle is four clk_sys quarters: decode, read, process, write.
// Notes on behaviour
// - clear op zeroes byte, sets zero flag.
// - access bit low uses access bank, else bank register.
// - extended set, low address uses indexed mode.
// - watchdog clear zeroes counter and postscaler.
// - watchdog clear sets both status flags high.
// - invert op complements byte, updates N and Z.
// - destination bit picks working register or memory.
// - compare op tests equality, flags untouched.
// - equal compare discards next, adds one nop.
// - skipped two-word instruction adds two nops.
// - call pushes address plus four, loads target.
// - call shadow bit saves W, bank, flags.
// - call loads 20-bit literal, takes two cycles.
`timescale 1ns/1ps
module clear_complement_compare_exec (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  exec_pkg::exec_state_t state_ff;
  logic [1:0] q_ff;
  logic [1:0] nop_left_ff;
  logic [15:0] instr_ff;
  logic [15:0] next_ff;
  logic [7:0] rd_ff;
  logic [7:0] w_ff;
  logic [4:0] flags_ff;
  logic [3:0] bsr_ff;
  logic [7:0] w_shadow_ff;
  logic [3:0] bank_select_shadow_ff;
  logic [4:0] flags_shadow_ff;
  logic [20:0] pc_ff;
  logic [20:0] stack_top_ff;
  logic [4:0] depth_ff;
  logic ext_en_ff;
  logic [11:0] index_base_ff;
  logic [11:0] maddr_ff;
  logic watchdog_expired_n_ff;
  logic powerdown_flag_n_ff;
  logic [1:0] last_cycles_ff;
  logic unsupported_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [7:0] dmem [0:4095];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Writes are refused while an instruction runs so the core never races software.
  wire busy = (state_ff != exec_pkg::ST_IDLE);
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr_ok = bus_req & wb_we_i & (|wb_sel_i) & ~busy;
  wire hit_ctrl = (wb_adr_i == exec_pkg::OFS_CTRL);
  wire hit_instr = (wb_adr_i == exec_pkg::OFS_INSTR);
  wire hit_next = (wb_adr_i == exec_pkg::OFS_NEXT);
  wire hit_wreg = (wb_adr_i == exec_pkg::OFS_WREG);
  wire hit_flags = (wb_adr_i == exec_pkg::OFS_FLAGS);
  wire hit_bank = (wb_adr_i == exec_pkg::OFS_BANK);
  wire hit_wdog = (wb_adr_i == exec_pkg::OFS_WDOG);
  wire hit_pc = (wb_adr_i == exec_pkg::OFS_PC);
  wire hit_stack = (wb_adr_i == exec_pkg::OFS_STACK);
  wire hit_shadow = (wb_adr_i == exec_pkg::OFS_SHADOW);
  wire hit_index = (wb_adr_i == exec_pkg::OFS_INDEX);
  wire hit_maddr = (wb_adr_i == exec_pkg::OFS_MADDR);
  wire hit_mdata = (wb_adr_i == exec_pkg::OFS_MDATA);
  wire hit_exec = (wb_adr_i == exec_pkg::OFS_EXEC);
  wire launch = wr_ok & hit_instr;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire is_clear = (instr_ff[15:9] == exec_pkg::OPC_CLEAR_HI);
  wire is_wdog_clear = (instr_ff == exec_pkg::OPC_WATCHDOG_CLEAR);
  wire is_invert = (instr_ff[15:10] == exec_pkg::OPC_INVERT_HI);
  wire is_compare = (instr_ff[15:9] == exec_pkg::OPC_COMPARE_HI);
  wire is_call = (instr_ff[15:9] == exec_pkg::OPC_CALL_HI);
  wire is_known = is_clear | is_wdog_clear | is_invert | is_compare | is_call;
  wire dest_mem = instr_ff[9];
  wire save_shadow = instr_ff[8];
  wire [19:0] call_target = {next_ff[11:0], instr_ff[7:0]};
  // A skipped word that opens a two-word instruction costs an extra nop.
  wire next_two_word = (next_ff[15:12] == exec_pkg::OPC_MOVE_HI)
                     | (next_ff[15:9] == exec_pkg::OPC_CALL_HI)
                     | (next_ff[15:8] == exec_pkg::OPC_LOAD_INDEX)
                     | (next_ff[15:8] == exec_pkg::OPC_GOTO);
  wire [11:0] op_addr;
  operand_address u_addr (
    .file_addr(instr_ff[7:0]),
    .access_sel(instr_ff[8]),
    .ext_enable(ext_en_ff),
    .bank(bsr_ff),
    .index_base(index_base_ff),
    .data_addr(op_addr),
    .indexed()
  );

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  wire at_read = (state_ff == exec_pkg::ST_RUN) & (q_ff == exec_pkg::Q_READ);
  wire at_process = (state_ff == exec_pkg::ST_RUN) & (q_ff == exec_pkg::Q_PROCESS);
  wire commit = (state_ff == exec_pkg::ST_RUN) & (q_ff == exec_pkg::Q_WRITE);
  wire [7:0] inv_res = ~rd_ff;
  wire cmp_eq = (rd_ff == w_ff);
  wire skip = is_compare & cmp_eq;
  wire [1:0] skip_words = skip ? (next_two_word ? 2'h2 : 2'h1) : 2'h0;
  wire [1:0] nops_needed = is_call ? 2'h1 : skip_words;
  wire [20:0] pc_after = pc_ff + (21'({19'h0, skip_words}) + 21'h000001) * exec_pkg::PC_STEP;
  wire [20:0] nxt_pc = is_call ? {call_target, 1'b0} : pc_after;
  wire mem_we_exec = commit & (is_clear | (is_invert & dest_mem));
  wire [7:0] mem_wdata = is_clear ? 8'h00 : inv_res;
  wire wdt_clear = at_process & is_wdog_clear;
  wire [7:0] wdt_count;
  wire [3:0] wdt_post;
  wire wdt_expire;
  watchdog_timer u_wdt (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(wdt_clear),
    .count_o(wdt_count),
    .post_o(wdt_post),
    .expire_o(wdt_expire)
  );

  // ----------------------------------------------------------------
  // Quarter sequencer
  // ----------------------------------------------------------------
  // Four quarters per instruction cycle, then whole nop cycles if needed.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= exec_pkg::ST_IDLE;
      q_ff <= exec_pkg::Q_DECODE;
      nop_left_ff <= 2'h0;
    end else begin
      unique case (state_ff)
        exec_pkg::ST_IDLE: begin
          q_ff <= exec_pkg::Q_DECODE;
          if (launch) begin
            state_ff <= exec_pkg::ST_RUN;
          end
        end
        exec_pkg::ST_RUN: begin
          q_ff <= q_ff + 2'h1;
          if (commit) begin
            nop_left_ff <= nops_needed;
            state_ff <= (nops_needed != 2'h0) ? exec_pkg::ST_NOP : exec_pkg::ST_IDLE;
          end
        end
        exec_pkg::ST_NOP: begin
          q_ff <= q_ff + 2'h1;
          if (q_ff == exec_pkg::Q_WRITE) begin
            nop_left_ff <= nop_left_ff - 2'h1;
            if (nop_left_ff == 2'h1) begin
              state_ff <= exec_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end
  // Instruction words and the read operand.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      instr_ff <= 16'h0000;
      next_ff <= 16'h0000;
      rd_ff <= 8'h00;
    end else begin
      if (launch) begin
        instr_ff <= wb_dat_i[15:0];
      end
      if (wr_ok && hit_next) begin
        next_ff <= wb_dat_i[15:0];
      end
      if (at_read) begin
        rd_ff <= dmem[op_addr];
      end
    end
  end
  // Data memory has a single write port shared by core and bus; they never overlap.
  always_ff @(posedge clk_sys) begin
    if (mem_we_exec) begin
      dmem[op_addr] <= mem_wdata;
    end else if (wr_ok && hit_mdata) begin
      dmem[maddr_ff] <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  // Working register, status flags and bank select.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      w_ff <= exec_pkg::WREG_RST;
      flags_ff <= exec_pkg::FLAGS_RST;
      bsr_ff <= 4'h0;
    end else if (commit) begin
      if (is_invert && !dest_mem) begin
        w_ff <= inv_res;
      end
      if (is_clear) begin
        flags_ff[exec_pkg::FLAG_Z] <= 1'b1;
      end
      if (is_invert) begin
        flags_ff[exec_pkg::FLAG_N] <= inv_res[7];
        flags_ff[exec_pkg::FLAG_Z] <= (inv_res == 8'h00);
      end
    end else if (wr_ok) begin
      if (hit_wreg) begin
        w_ff <= wb_dat_i[7:0];
      end
      if (hit_flags) begin
        flags_ff <= wb_dat_i[4:0];
      end
      if (hit_bank) begin
        bsr_ff <= wb_dat_i[3:0];
      end
    end
  end
  // Program counter, return stack top and shadow copies.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pc_ff <= 21'h000000;
      stack_top_ff <= 21'h000000;
      depth_ff <= 5'h00;
      w_shadow_ff <= 8'h00;
      bank_select_shadow_ff <= 4'h0;
      flags_shadow_ff <= 5'h00;
    end else if (commit) begin
      pc_ff <= is_known ? nxt_pc : pc_ff + exec_pkg::PC_STEP;
      if (is_call) begin
        stack_top_ff <= pc_ff + exec_pkg::RETURN_OFFSET;
        depth_ff <= (depth_ff == 5'h1f) ? depth_ff : depth_ff + 5'h01;
        if (save_shadow) begin
          w_shadow_ff <= w_ff;
          bank_select_shadow_ff <= bsr_ff;
          flags_shadow_ff <= flags_ff;
        end
      end
    end else if (wr_ok && hit_pc) begin
      pc_ff <= {wb_dat_i[20:1], 1'b0};
    end
  end
  // Watchdog status flags; the clear instruction beats a simultaneous expiry.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      watchdog_expired_n_ff <= 1'b1;
      powerdown_flag_n_ff <= 1'b1;
    end else if (wdt_clear) begin
      watchdog_expired_n_ff <= 1'b1;
      powerdown_flag_n_ff <= 1'b1;
    end else begin
      if (wdt_expire) begin
        watchdog_expired_n_ff <= 1'b0;
      end
      if (wr_ok && hit_wdog) begin
        powerdown_flag_n_ff <= wb_dat_i[exec_pkg::WDOG_POWERDOWN_N];
      end
    end
  end
  // Control, index base, memory pointer and execution record.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_en_ff <= 1'b0;
      index_base_ff <= 12'h000;
      maddr_ff <= 12'h000;
      last_cycles_ff <= 2'h0;
      unsupported_ff <= 1'b0;
    end else begin
      if (wr_ok && hit_ctrl) begin
        ext_en_ff <= wb_dat_i[exec_pkg::CTRL_EXT];
      end
      if (wr_ok && hit_index) begin
        index_base_ff <= wb_dat_i[11:0];
      end
      if (wr_ok && hit_maddr) begin
        maddr_ff <= wb_dat_i[11:0];
      end
      if (commit) begin
        last_cycles_ff <= nops_needed + 2'h1;
        unsupported_ff <= ~is_known;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  // Unmapped addresses still acknowledge and read as zero.
  wire [31:0] rd_mux =
      hit_ctrl ? {31'h0, ext_en_ff} :
      hit_instr ? {16'h0, instr_ff} :
      hit_next ? {16'h0, next_ff} :
      hit_wreg ? {24'h0, w_ff} :
      hit_flags ? {27'h0, flags_ff} :
      hit_bank ? {28'h0, bsr_ff} :
      hit_wdog ? {16'h0, wdt_count, wdt_post, 2'h0, powerdown_flag_n_ff, watchdog_expired_n_ff} :
      hit_pc ? {11'h0, pc_ff} :
      hit_stack ? {6'h0, depth_ff, stack_top_ff} :
      hit_shadow ? {11'h0, flags_shadow_ff, 4'h0, bank_select_shadow_ff, w_shadow_ff} :
      hit_index ? {20'h0, index_base_ff} :
      hit_maddr ? {20'h0, maddr_ff} :
      hit_mdata ? {24'h0, dmem[maddr_ff]} :
      hit_exec ? {28'h0, unsupported_ff, last_cycles_ff, busy} :
      32'h0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= bus_req;
      if (bus_req) begin
        dat_ff <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule

/* File: exec_checker_assertions.sv */
// Purpose: Port-level checks of the clear, complement and compare execution block.
// Assumes: Writes made while an instruction runs are refused and leave the record intact.
// Notes: Results are judged on register reads made after completion has been seen.
`timescale 1ns/1ps
module exec_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o
);
  // ----------------------------------------------------------------
  // Record of the last launched instruction
  // ----------------------------------------------------------------
  logic [15:0] op_ff;
  logic [9:0] age_ff;
  logic [4:0] flg_ff;
  logic valid_ff, done_ff;
  wire logic take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = take & wb_we_i & (|wb_sel_i);
  wire logic rd = wb_ack_o & ~wb_we_i & valid_ff;
  wire logic exec_rd = rd & (wb_adr_i == exec_pkg::OFS_EXEC) & ~wb_dat_o[0];
  wire logic sees = rd & done_ff;
  wire logic is_clr = op_ff[15:9] == exec_pkg::OPC_CLEAR_HI;
  wire logic is_cmp = op_ff[15:9] == exec_pkg::OPC_COMPARE_HI;
  wire logic is_call = op_ff[15:9] == exec_pkg::OPC_CALL_HI;
  wire logic is_inv = op_ff[15:10] == exec_pkg::OPC_INVERT_HI;
  wire logic is_wd = op_ff == exec_pkg::OPC_WATCHDOG_CLEAR;
  wire logic wd_rd = sees & is_wd & (wb_adr_i == exec_pkg::OFS_WDOG) & (age_ff < 10'h0c8);

  // A write after completion voids the record, because it may alter what is read back.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_ff <= 16'h0000;
      age_ff <= 10'h000;
      flg_ff <= 5'h00;
      valid_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      age_ff <= (age_ff == 10'h3ff) ? age_ff : age_ff + 10'h001;
      if (wr & (wb_adr_i == exec_pkg::OFS_INSTR)) begin
        op_ff <= wb_dat_i[15:0];
        age_ff <= 10'h000;
        valid_ff <= 1'b1;
        done_ff <= 1'b0;
      end else if (wr & done_ff) begin
        valid_ff <= 1'b0;
      end
      if (exec_rd) done_ff <= 1'b1;
      if (wr & (wb_adr_i == exec_pkg::OFS_FLAGS)) flg_ff <= wb_dat_i[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  ack_one_wait_a:
    assert property (take |=> wb_ack_o) else $error("ack did not follow request");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_has_cause_a:
    assert property ($rose(wb_ack_o) |-> $past(take)) else $error("ack without request");
  clear_zero_flag_a:
    assert property (sees & is_clr & (wb_adr_i == exec_pkg::OFS_FLAGS) |-> wb_dat_o[exec_pkg::FLAG_Z])
    else $error("clear left zero flag low");
  compare_flags_a:
    assert property (sees & is_cmp & (wb_adr_i == exec_pkg::OFS_FLAGS) |-> wb_dat_o[4:0] == flg_ff)
    else $error("compare changed flags");
  wdog_flags_a:
    assert property (wd_rd |-> wb_dat_o[1:0] == 2'b11) else $error("watchdog status not set");
  wdog_post_a:
    assert property (wd_rd |-> wb_dat_o[7:4] == 4'h0) else $error("postscaler not cleared");
  call_two_cycles_a:
    assert property (exec_rd & is_call |-> wb_dat_o[2:1] == 2'h2) else $error("call cycle count wrong");
  single_cycle_a:
    assert property (exec_rd & (is_clr | is_inv | is_wd) |-> wb_dat_o[2:1] == 2'h1)
    else $error("one-cycle op took longer");
  skip_cycles_a:
    assert property (exec_rd & is_cmp |-> wb_dat_o[2:1] != 2'h0) else $error("compare cycle count wrong");
  cover property (exec_rd & is_cmp & (wb_dat_o[2:1] == 2'h3));
  cover property (exec_rd & is_call);
  cover property (wd_rd);
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the execution block over Wishbone.
// Assumes: Every transfer is answered; the bench waits for ack and polls busy after each launch.
// Notes: A bench model predicts W, flags, PC, stack, shadow, watchdog status, cycle count and operand byte after each instruction.
`timescale 1ns/1ps
module testbench;
  logic clk_sys, reset, cyc, stb, we, two;
  logic [7:0] adr, f, mv, w_m, shw_m, mem_m[4096];
  logic [3:0] sel, bk_m, shb_m;
  logic [31:0] dat, dato, rv;
  logic [4:0] fl_m, shf_m;
  logic [20:0] pc_m, st_m;
  logic [11:0] ix_m, ad;
  logic [15:0] i, nx;
  logic [1:0] wd_m, cy_m;
  logic ext_m, ack;
  int miscompares, checked, ticks, k;
  logic [15:0] base[12] = '{16'h6b00, 16'h6a00, 16'h1d00, 16'h1e00, 16'h6300, 16'h6300, 16'h6300,
                            16'hed00, 16'hec00, 16'h0004, 16'h1e00, 16'hf000};
  logic [15:0] tw[4] = '{16'hc123, 16'hed45, 16'hee00, 16'hef99};

  clear_complement_compare_exec uut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dato));

  // Free-running system clock, 8 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // A hang is cut short well beyond the few thousand cycles the run needs.
  always @(posedge clk_sys) begin
    ticks <= ticks + 1;
    if (ticks == 30000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------------------------------
  // One classic cycle; the request is held until ack is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1) @(posedge clk_sys);
    rv = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(n, rv & m, e);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bench model
  // ----------------------------------------------------------------
  // Operand address; the plain access-bank low half is met only by ops that touch no operand, so the model maps it like the high half.
  function automatic logic [11:0] eaddr(input logic [15:0] op);
    if (op[8]) return {bk_m, op[7:0]};
    if (ext_m && op[7:0] <= 8'h5f) return ix_m + {4'h0, op[7:0]};
    return {4'hf, op[7:0]};
  endfunction

  task automatic model(input logic [15:0] op, input logic [15:0] n2);
    logic [7:0] r;
    r = ~mem_m[ad];
    cy_m = 2'h1;
    pc_m = pc_m + 21'h2;
    if (op == 16'h0004) wd_m = 2'b11;
    if (op[15:9] == 7'h35) begin
      mem_m[ad] = 8'h00;
      fl_m[2] = 1'b1;
    end
    if (op[15:10] == 6'h07) begin
      if (op[9]) mem_m[ad] = r;
      else w_m = r;
      fl_m[4] = r[7];
      fl_m[2] = (r == 8'h00);
    end
    if (op[15:9] == 7'h31 && mem_m[ad] == w_m) begin
      two = n2[15:12] == 4'hc || n2[15:9] == 7'h76 || n2[15:9] == 7'h77;
      cy_m = two ? 2'h3 : 2'h2;
      pc_m = pc_m + (two ? 21'h4 : 21'h2);
    end
    if (op[15:9] == 7'h76) begin
      st_m = pc_m + 21'h2;
      if (op[8]) {shw_m, shb_m, shf_m} = {w_m, bk_m, fl_m};
      pc_m = {n2[11:0], op[7:0], 1'b0};
      cy_m = 2'h2;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset, cyc, stb, we, adr, dat, miscompares, checked} = '0;
    sel = 4'hf;
    {w_m, fl_m, pc_m, st_m, shw_m, shb_m, shf_m} = '0;
    reset = 1'b1;
    void'($urandom(32'h2f6d));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdchk("wreg", 8'h0c, 32'hff, 32'h0);
    rdchk("flags", 8'h10, 32'h1f, 32'h0);
    rdchk("wdog", 8'h18, 32'h3, 32'h3);
    rdchk("stack", 8'h20, 32'h3ffffff, 32'h0);
    rdchk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    for (int n = 0; n < 48; n++) begin
      k = n % 12;
      f = 8'($urandom);
      if (k == 1 || k == 10) f = f % 8'h60;
      if (k == 3) f = f | 8'h80;
      i = (k == 9) ? 16'h0004 : base[k] | {8'h00, f};
      nx = (k == 6) ? tw[n / 12] : (k == 7 || k == 8) ? 16'($urandom) : {4'h0, 12'($urandom)};
      ext_m = (k == 1 || k == 10);
      ix_m = 12'($urandom);
      {bk_m, w_m, fl_m, mv} = 25'($urandom);
      pc_m = 21'($urandom) & ~21'h1;
      ad = eaddr(i);
      if (k == 4 || k == 6) w_m = mv;
      if (k == 5) w_m = mv ^ 8'h5a;
      mem_m[ad] = mv;
      wd_m = 2'b00;
      xfer(1'b1, 8'h00, {31'h0, ext_m});
      xfer(1'b1, 8'h28, {20'h0, ix_m});
      xfer(1'b1, 8'h14, {28'h0, bk_m});
      xfer(1'b1, 8'h0c, {24'h0, w_m});
      xfer(1'b1, 8'h10, {27'h0, fl_m});
      xfer(1'b1, 8'h1c, {11'h0, pc_m});
      xfer(1'b1, 8'h2c, {20'h0, ad});
      xfer(1'b1, 8'h30, {24'h0, mv});
      xfer(1'b1, 8'h18, 32'h0);
      xfer(1'b1, 8'h08, {16'h0, nx});
      xfer(1'b1, 8'h04, {16'h0, i});
      xfer(1'b1, 8'h0c, 32'ha5);
      xfer(1'b0, 8'h34, 32'h0);
      while (rv[0] !== 1'b0) xfer(1'b0, 8'h34, 32'h0);
      model(i, nx);
      check("cycles", {29'h0, rv[3:1]}, {29'h0, k == 11, cy_m});
      rdchk("wreg", 8'h0c, 32'hff, {24'h0, w_m});
      rdchk("flags", 8'h10, 32'h1f, {27'h0, fl_m});
      rdchk("pc", 8'h1c, 32'h1fffff, {11'h0, pc_m});
      rdchk("stack", 8'h20, 32'h1fffff, {11'h0, st_m});
      rdchk("shadow", 8'h24, 32'h1f0fff, {11'h0, shf_m, 4'h0, shb_m, shw_m});
      rdchk("wdog", 8'h18, (k == 9) ? 32'hf3 : 32'h2, {30'h0, wd_m});
      xfer(1'b1, 8'h2c, {20'h0, ad});
      rdchk("mdata", 8'h30, 32'hff, {24'h0, mem_m[ad]});
    end
    finish_test();
  end
endmodule

bind clear_complement_compare_exec exec_checker chk (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
